// File: src/gpio_ports.sv
// Seven general-purpose I/O ports with their alternate-function selection
`default_nettype none

module gpio_ports (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [gpio_pkg::ADDR_W-1:0] i_addr,
   input wire logic [gpio_pkg::PORT_W-1:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   output logic [gpio_pkg::PORT_W-1:0] o_rdata,
   // Pins
   input wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::PORT_W-1:0] i_pin_in,
   output gpio_pkg::gpio_pad_t [gpio_pkg::NUM_PORTS-1:0] o_pad,
   // Peripheral functions sharing the pins
   input wire gpio_pkg::gpio_pad_t [gpio_pkg::NUM_PORTS-1:0] i_periph,
   output logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::PORT_W-1:0] o_periph_in,
   // External bus controller
   input wire logic [gpio_pkg::PORT_W-1:0] i_ext_addr_high,
   input wire gpio_pkg::gpio_busctl_t i_busctl,
   output logic o_hold_request,
   output logic o_wait_request,
   // Analog input path
   output logic [gpio_pkg::PORT_W-1:0] o_analog_pin_enable
);

   localparam int NP = gpio_pkg::NUM_PORTS;
   localparam int PW = gpio_pkg::PORT_W;

   // Software-visible registers
   logic [NP-1:0][PW-1:0] port_value_reg;
   logic [NP-1:0][PW-1:0] port_direction;
   logic [PW-1:0] high_address_output_enable;
   logic [PW-1:0] bus_control_pin_select;
   logic [PW-1:0] analog_pin_enable;
   logic [NP-1:0][PW-1:0] next_port_value_reg;
   logic [NP-1:0][PW-1:0] next_port_direction;
   logic [PW-1:0] next_high_address_output_enable;
   logic [PW-1:0] next_bus_control_pin_select;
   logic [PW-1:0] next_analog_pin_enable;

   // Read path
   logic [PW-1:0] rdata;
   logic [PW-1:0] next_rdata;

   // Pin drive and sampled levels
   gpio_pkg::gpio_pad_t [NP-1:0] pad;
   gpio_pkg::gpio_pad_t [NP-1:0] next_pad;
   logic [NP-1:0][PW-1:0] periph_in;
   logic [NP-1:0][PW-1:0] next_periph_in;
   logic [NP-1:0][PW-1:0] pin_level;
   logic hold_request;
   logic next_hold_request;
   logic wait_request;
   logic next_wait_request;

   // Decoded register index
   logic [gpio_pkg::ADDR_W-2:0] port_index;
   logic port_hit;
   logic dir_select;

   // Pin levels pass three stages before anyone looks at them
   gpio_sync #(
      .WIDTH(gpio_pkg::PIN_TOTAL)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_async(i_pin_in),
      .o_level(pin_level)
   );

   // Port registers sit in pairs, so the low address bit picks direction
   assign port_index = i_addr[gpio_pkg::ADDR_W-1:1];
   assign dir_select = i_addr[0];
   assign port_hit = (i_addr >= gpio_pkg::ADDR_PORT_BASE) &&
      (i_addr <= gpio_pkg::ADDR_PORT_LAST);

   // Register writes; bits without a pin are never stored
   always_comb
   begin
      next_port_value_reg = port_value_reg;
      next_port_direction = port_direction;
      next_high_address_output_enable = high_address_output_enable;
      next_bus_control_pin_select = bus_control_pin_select;
      next_analog_pin_enable = analog_pin_enable;
      if (i_we)
      begin
         if (port_hit && !dir_select)
         begin
            next_port_value_reg[port_index] = i_wdata &
               gpio_pkg::PORT_MASK[port_index];
         end
         else if (port_hit && dir_select)
         begin
            next_port_direction[port_index] = i_wdata &
               gpio_pkg::PORT_MASK[port_index];
         end
         else if (i_addr == gpio_pkg::ADDR_HIGH_ADDR)
         begin
            next_high_address_output_enable = i_wdata;
         end
         else if (i_addr == gpio_pkg::ADDR_BUS_SEL)
         begin
            next_bus_control_pin_select = i_wdata &
               gpio_pkg::SEL_MASK;
         end
         else if (i_addr == gpio_pkg::ADDR_ANALOG)
         begin
            next_analog_pin_enable = i_wdata;
         end
      end
   end

   // Registers clear at reset: all pins inputs, alternates off
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         port_value_reg <= '0;
         port_direction <= '0;
         high_address_output_enable <= gpio_pkg::REG_RESET;
         bus_control_pin_select <= gpio_pkg::REG_RESET;
         analog_pin_enable <= gpio_pkg::REG_RESET;
      end
      else
      begin
         port_value_reg <= next_port_value_reg;
         port_direction <= next_port_direction;
         high_address_output_enable <= next_high_address_output_enable;
         bus_control_pin_select <= next_bus_control_pin_select;
         analog_pin_enable <= next_analog_pin_enable;
      end
   end

   // Read mux: output pins show the stored bit, input pins their level
   always_comb
   begin
      next_rdata = gpio_pkg::REG_RESET;
      if (i_re)
      begin
         if (port_hit && !dir_select)
         begin
            next_rdata = ((port_direction[port_index] &
               port_value_reg[port_index]) |
               (~port_direction[port_index] &
               pin_level[port_index])) &
               gpio_pkg::PORT_MASK[port_index];
            if (port_index == gpio_pkg::PORT_ANALOG)
            begin
               // Analog pins would toggle digital reads, so they read 0
               next_rdata = next_rdata & ~analog_pin_enable;
            end
         end
         else if (port_hit && dir_select)
         begin
            next_rdata = port_direction[port_index];
         end
         else if (i_addr == gpio_pkg::ADDR_HIGH_ADDR)
         begin
            next_rdata = high_address_output_enable;
         end
         else if (i_addr == gpio_pkg::ADDR_BUS_SEL)
         begin
            next_rdata = bus_control_pin_select;
         end
         else if (i_addr == gpio_pkg::ADDR_ANALOG)
         begin
            next_rdata = analog_pin_enable;
         end
      end
   end

   // Read data stand for exactly one cycle after the strobe
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         rdata <= gpio_pkg::REG_RESET;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end

   // Pin owner per bit: address, bus control, analog, peripheral, port
   always_comb
   begin
      next_pad = '0;
      for (int p = 0; p < NP; p++)
      begin
         for (int b = 0; b < PW; b++)
         begin
            if (!gpio_pkg::PORT_MASK[p][b])
            begin
               // No pin behind this bit: stays undriven
               next_pad[p].out[b] = 1'b0;
               next_pad[p].oe[b] = 1'b0;
            end
            else if (p == gpio_pkg::PORT_HIGH_ADDR &&
               high_address_output_enable[b])
            begin
               next_pad[p].out[b] = i_ext_addr_high[b];
               next_pad[p].oe[b] = 1'b1;
            end
            else if (p == gpio_pkg::PORT_BUS_CTRL &&
               bus_control_pin_select[gpio_pkg::SEL_WRITE_BIT] &&
               (b == gpio_pkg::PIN_WR_LOW || b == gpio_pkg::PIN_WR_HIGH))
            begin
               next_pad[p].out[b] = (b == gpio_pkg::PIN_WR_LOW) ?
                  i_busctl.wr_low : i_busctl.wr_high;
               next_pad[p].oe[b] = 1'b1;
            end
            else if (p == gpio_pkg::PORT_BUS_CTRL &&
               bus_control_pin_select[gpio_pkg::SEL_HOLD_BIT] &&
               (b == gpio_pkg::PIN_HOLD_REQ || b == gpio_pkg::PIN_HOLD_ACK))
            begin
               // Request comes in, acknowledge goes out
               next_pad[p].out[b] = (b == gpio_pkg::PIN_HOLD_ACK) &
                  i_busctl.hold_ack;
               next_pad[p].oe[b] = (b == gpio_pkg::PIN_HOLD_ACK);
            end
            else if (p == gpio_pkg::PORT_BUS_CTRL &&
               bus_control_pin_select[gpio_pkg::SEL_WAIT_BIT] &&
               b == gpio_pkg::PIN_WAIT)
            begin
               next_pad[p].out[b] = 1'b0;
               next_pad[p].oe[b] = 1'b0;
            end
            else if (p == gpio_pkg::PORT_BUS_CTRL &&
               bus_control_pin_select[gpio_pkg::SEL_CLK_BIT] &&
               b == gpio_pkg::PIN_CLK)
            begin
               next_pad[p].out[b] = i_busctl.clk;
               next_pad[p].oe[b] = 1'b1;
            end
            else if (p == gpio_pkg::PORT_ANALOG && analog_pin_enable[b])
            begin
               // Driving an analog input would corrupt the conversion
               next_pad[p].out[b] = 1'b0;
               next_pad[p].oe[b] = 1'b0;
            end
            else if (i_periph[p].oe[b])
            begin
               next_pad[p].out[b] = i_periph[p].out[b];
               next_pad[p].oe[b] = 1'b1;
            end
            else
            begin
               next_pad[p].out[b] = port_value_reg[p][b];
               next_pad[p].oe[b] = port_direction[p][b];
            end
         end
      end
   end

   // Peripheral inputs and bus control inputs from filtered pins
   always_comb
   begin
      next_periph_in = pin_level & gpio_pkg::PORT_MASK;
      next_periph_in[gpio_pkg::PORT_ANALOG] =
         pin_level[gpio_pkg::PORT_ANALOG] & ~analog_pin_enable;
      next_hold_request =
         bus_control_pin_select[gpio_pkg::SEL_HOLD_BIT] &
         pin_level[gpio_pkg::PORT_BUS_CTRL][gpio_pkg::PIN_HOLD_REQ];
      next_wait_request =
         bus_control_pin_select[gpio_pkg::SEL_WAIT_BIT] &
         pin_level[gpio_pkg::PORT_BUS_CTRL][gpio_pkg::PIN_WAIT];
   end

   // Every output leaves from a flip-flop
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         pad <= '0;
         periph_in <= '0;
         hold_request <= 1'b0;
         wait_request <= 1'b0;
      end
      else
      begin
         pad <= next_pad;
         periph_in <= next_periph_in;
         hold_request <= next_hold_request;
         wait_request <= next_wait_request;
      end
   end

   // Outputs
   assign o_rdata = rdata;
   assign o_pad = pad;
   assign o_periph_in = periph_in;
   assign o_hold_request = hold_request;
   assign o_wait_request = wait_request;
   assign o_analog_pin_enable = analog_pin_enable;

endmodule // gpio_ports

`default_nettype wire

// File: src/gpio_pkg.sv
// Package with constants and types of the general-purpose I/O ports
`default_nettype none

package gpio_pkg;

   // Port geometry
   localparam int NUM_PORTS = 7;
   localparam int PORT_W = 8;
   localparam int ADDR_W = 5;
   localparam int PIN_TOTAL = NUM_PORTS * PORT_W;

   // Implemented pins per port, entry 6 first; 49 pins in all
   localparam logic [NUM_PORTS-1:0][PORT_W-1:0] PORT_MASK = {
      8'h0f, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'hff};

   // Register offsets: data of port k at 2k, direction at 2k + 1
   localparam logic [ADDR_W-1:0] ADDR_PORT_BASE = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_PORT_LAST = 5'h0d;
   localparam logic [ADDR_W-1:0] ADDR_HIGH_ADDR = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_BUS_SEL = 5'h11;
   localparam logic [ADDR_W-1:0] ADDR_ANALOG = 5'h12;

   // Reset value of every register, and the all-ones pattern
   localparam logic [PORT_W-1:0] REG_RESET = 8'h00;
   localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;

   // Ports that carry alternate functions
   localparam int PORT_HIGH_ADDR = 2;
   localparam int PORT_BUS_CTRL = 3;
   localparam int PORT_ANALOG = 5;

   // Bit positions in bus_control_pin_select
   localparam int SEL_CLK_BIT = 7;
   localparam int SEL_WAIT_BIT = 6;
   localparam int SEL_HOLD_BIT = 5;
   localparam int SEL_WRITE_BIT = 3;
   localparam logic [PORT_W-1:0] SEL_MASK = 8'he8;

   // Port 3 pins used by the external bus control signals
   localparam int PIN_WR_LOW = 2;
   localparam int PIN_WR_HIGH = 3;
   localparam int PIN_HOLD_REQ = 4;
   localparam int PIN_HOLD_ACK = 5;
   localparam int PIN_WAIT = 6;
   localparam int PIN_CLK = 7;

   // Drive of one port: level and output enable per pin
   typedef struct packed {
      logic [PORT_W-1:0] out;
      logic [PORT_W-1:0] oe;
   } gpio_pad_t;

   // Signals of the external bus controller routed to port 3
   typedef struct packed {
      logic wr_low;
      logic wr_high;
      logic hold_ack;
      logic clk;
   } gpio_busctl_t;

endpackage : gpio_pkg

`default_nettype wire

// File: src/gpio_sync.sv
// Three-stage input synchroniser with agreement filter per bit
`default_nettype none

module gpio_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Asynchronous levels in, filtered levels out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_level
);

   genvar g;

   // One chain per bit; the first stage feeds only the second
   generate
      for (g = 0; g < WIDTH; g++)
      begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         logic level;
         logic next_level;

         // Level moves only when the two later stages agree
         always_comb
         begin
            next_level = level;
            if (s2 == s3)
            begin
               next_level = s3;
            end
         end

         always_ff @(posedge i_sys_clk)
         begin
            if (i_rst)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               level <= 1'b0;
            end
            else
            begin
               s1 <= i_async[g];
               s2 <= s1;
               s3 <= s2;
               level <= next_level;
            end
         end

         assign o_level[g] = level;
      end
   endgenerate

endmodule // gpio_sync

`default_nettype wire

// File: tb/gpio_ports_properties.sv
// Concurrent checks on the I/O port block, bound to its top module
`default_nettype none

module gpio_ports_properties (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // Register port
   input wire logic [gpio_pkg::ADDR_W-1:0] i_addr,
   input wire logic [gpio_pkg::PORT_W-1:0] i_wdata,
   input wire logic i_we,
   input wire logic i_re,
   input wire logic [gpio_pkg::PORT_W-1:0] o_rdata,
   // Pins and alternate sources
   input wire gpio_pkg::gpio_pad_t [gpio_pkg::NUM_PORTS-1:0] o_pad,
   input wire gpio_pkg::gpio_pad_t [gpio_pkg::NUM_PORTS-1:0] i_periph,
   input wire logic [gpio_pkg::PORT_W-1:0] i_ext_addr_high,
   input wire logic o_hold_request,
   input wire logic o_wait_request,
   input wire logic [gpio_pkg::PORT_W-1:0] o_analog_pin_enable
);
   timeunit 1ns;
   timeprecision 1ps;

   // One clock domain, so one clocking and one reset for all checks
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   a_rdata_idle: assert property (!$past(i_re) |-> o_rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   a_pad_unimpl: assert property (o_pad[6].oe[7:4] == 4'h0 &&
      o_pad[4].oe[7:5] == 3'h0) else $error("pin without pad driven");
   a_analog_write: assert property (i_we &&
      i_addr == gpio_pkg::ADDR_ANALOG |=> o_analog_pin_enable == $past(i_wdata))
      else $error("analog enable not taken from write");
   a_analog_pad: assert property (
      (o_pad[5].oe & $past(o_analog_pin_enable)) == 8'h00)
      else $error("analog pin still driven");
   a_high_addr: assert property (i_we &&
      i_addr == gpio_pkg::ADDR_HIGH_ADDR && i_wdata == gpio_pkg::ALL_ONES ##1 1
      |=> o_pad[2].oe == gpio_pkg::ALL_ONES &&
      o_pad[2].out == $past(i_ext_addr_high))
      else $error("high address not on port 2");
   a_dir_drive: assert property (i_we && i_addr == 5'h01 ##1
      i_periph[0].oe == 8'h00 |=> o_pad[0].oe == $past(i_wdata, 2))
      else $error("direction write not on port 0 enables");
   a_reset_state: assert property ($past(i_rst) |-> o_pad == '0 &&
      o_analog_pin_enable == 8'h00 && !o_hold_request && !o_wait_request)
      else $error("outputs not idle after reset");
   a_port4_read: assert property (i_re &&
      (i_addr == 5'h08 || i_addr == 5'h09) |=> o_rdata[7:5] == 3'h0)
      else $error("port 4 absent bits read nonzero");
   a_port6_read: assert property (i_re &&
      (i_addr == 5'h0c || i_addr == 5'h0d) |=> o_rdata[7:4] == 4'h0)
      else $error("port 6 absent bits read nonzero");
   a_periph_drive: assert property (i_periph[1].oe != 8'h00 |=>
      (o_pad[1].oe & $past(i_periph[1].oe)) == $past(i_periph[1].oe) &&
      ((o_pad[1].out ^ $past(i_periph[1].out)) & $past(i_periph[1].oe))
      == 8'h00) else $error("peripheral drive lost on port 1");
endmodule // gpio_ports_properties

bind gpio_ports gpio_ports_properties u_gpio_ports_properties (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata),
   .o_pad(o_pad), .i_periph(i_periph), .i_ext_addr_high(i_ext_addr_high),
   .o_hold_request(o_hold_request), .o_wait_request(o_wait_request),
   .o_analog_pin_enable(o_analog_pin_enable)
);

`default_nettype wire

// File: tb/gpio_board.sv
// Board model: resolves each port pin from device drive and board level
`default_nettype none

module gpio_board (
   // Device drive
   input wire gpio_pkg::gpio_pad_t [gpio_pkg::NUM_PORTS-1:0] i_pad,
   // Level the board holds on pins the device leaves free
   input wire logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::PORT_W-1:0] i_ext,
   // Resolved pin levels
   output logic [gpio_pkg::NUM_PORTS-1:0][gpio_pkg::PORT_W-1:0] o_level
);
   timeunit 1ns;
   timeprecision 1ps;

   // Device wins where it drives; the board pulls every free pin
   always_comb
   begin
      for (int k = 0; k < gpio_pkg::NUM_PORTS; k++)
      begin
         o_level[k] = (i_pad[k].oe & i_pad[k].out) | (~i_pad[k].oe & i_ext[k]);
      end
   end
endmodule // gpio_board

`default_nettype wire

// File: tb/gpio_ports_tb.sv
// Self-checking bench for the seven-port I/O block
`default_nettype none

module gpio_ports_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_sys_clk, i_rst, i_we, i_re, o_hold_request, o_wait_request;
   logic [4:0] i_addr;
   logic [7:0] i_wdata, i_ext_addr_high, ana, o_rdata, o_analog_pin_enable;
   logic [6:0][7:0] pins, periph_in, ext, dir, dat;
   gpio_pkg::gpio_pad_t [6:0] o_pad, i_periph;
   gpio_pkg::gpio_busctl_t i_busctl;
   int bad_count, samples_checked, seed, k;

   gpio_ports u_gpio_ports (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re),
      .o_rdata(o_rdata), .i_pin_in(pins), .o_pad(o_pad), .i_periph(i_periph),
      .o_periph_in(periph_in), .i_ext_addr_high(i_ext_addr_high),
      .i_busctl(i_busctl), .o_hold_request(o_hold_request),
      .o_wait_request(o_wait_request),
      .o_analog_pin_enable(o_analog_pin_enable));
   gpio_board u_gpio_board (.i_pad(o_pad), .i_ext(ext), .o_level(pins));

   // 20 MHz clock
   initial
   begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask

   // Settle, then step off the edge so outputs are sampled settled
   task automatic idle(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_we <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_we <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      @(posedge i_sys_clk);
      i_re <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_re <= 1'b0;
      #1 chk(o_rdata, e);
   endtask

   // Data read: stored bits on outputs, board level on inputs
   function automatic logic [7:0] exp_data(input int p);
      exp_data = ((dir[p] & dat[p]) | (~dir[p] & ext[p]))
         & gpio_pkg::PORT_MASK[p];
   endfunction

   task automatic results;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Guard against a hang
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      bad_count++;
      results();
   end

   initial
   begin
      seed = 61;
      // Reset asserted from time zero, strobes and buses idle
      i_rst = 1'b1;
      {i_we, i_re, i_addr, i_wdata, i_ext_addr_high, ana} = '0;
      i_periph = '0;
      i_busctl = '0;
      {ext, dir, dat} = '0;
      bad_count = 0;
      samples_checked = 0;
      repeat (8) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      // Every register and the unmapped places 0x0e and 0x0f read zero after reset
      for (k = 0; k < 19; k++) rd(k[4:0], 8'h00);
      $display("done: reset values");
      // Ports 4 and 6 fully driven first, then random traffic
      for (int n = 0; n < 40; n++)
      begin
         k = n < 2 ? 4 + 2 * n : {$random(seed)} % 7;
         dir[k] = n < 2 ? 8'hff : 8'($random(seed));
         dat[k] = n < 2 ? 8'hff : 8'($random(seed));
         ext[k] = 8'($random(seed));
         wr({k[3:0], 1'b0}, dat[k]);
         wr({k[3:0], 1'b1}, dir[k]);
         idle(6);
         rd({k[3:0], 1'b0}, exp_data(k));
         rd({k[3:0], 1'b1}, dir[k] & gpio_pkg::PORT_MASK[k]);
         chk(o_pad[k].oe, dir[k] & gpio_pkg::PORT_MASK[k]);
         chk(o_pad[k].out & o_pad[k].oe, exp_data(k) & dir[k]);
      end
      $display("done: random ports");
      // Analog takeover of a port 5 set to drive high
      ana = 8'($random(seed));
      // Board pulls port 5 high so a leaking analog pin would show
      ext[5] = 8'hff;
      wr(5'h0a, 8'hff);
      wr(5'h0b, 8'hff);
      wr(gpio_pkg::ADDR_ANALOG, ana);
      idle(6);
      chk(o_analog_pin_enable, ana);
      chk(o_pad[5].oe, ~ana);
      chk(periph_in[5], ~ana);
      rd(5'h0a, ~ana);
      rd(gpio_pkg::ADDR_ANALOG, ana);
      wr(gpio_pkg::ADDR_ANALOG, 8'h00);
      // High address lines on port 2
      i_ext_addr_high <= 8'($random(seed));
      wr(gpio_pkg::ADDR_HIGH_ADDR, 8'hff);
      idle(2);
      chk(o_pad[2].oe, 8'hff);
      chk(o_pad[2].out, i_ext_addr_high);
      rd(gpio_pkg::ADDR_HIGH_ADDR, 8'hff);
      wr(gpio_pkg::ADDR_HIGH_ADDR, 8'h00);
      $display("done: analog and address");
      // Bus control on port 3; hold request and wait pins held high
      i_busctl <= 4'($random(seed));
      wr(5'h07, 8'h00);
      ext[3] <= 8'h50;
      wr(gpio_pkg::ADDR_BUS_SEL, 8'hff);
      idle(6);
      rd(gpio_pkg::ADDR_BUS_SEL, gpio_pkg::SEL_MASK);
      chk(o_pad[3].oe, 8'hac);
      chk({o_pad[3].out[7], o_pad[3].out[5],
         o_pad[3].out[3:2], 4'h0},
         {i_busctl.clk, i_busctl.hold_ack, i_busctl.wr_high,
         i_busctl.wr_low, 4'h0});
      chk({6'h00, o_hold_request, o_wait_request}, 8'h03);
      ext[3] = 8'h00;
      idle(6);
      chk({6'h00, o_hold_request, o_wait_request}, 8'h00);
      wr(gpio_pkg::ADDR_BUS_SEL, 8'h00);
      $display("done: bus control");
      // Peripheral takes port 1 pins while the port is all inputs
      // Changed on the edge by non-blocking assignment to avoid a race
      i_periph[1] <= 16'($random(seed));
      ext[1] <= 8'($random(seed));
      wr(5'h03, 8'h00);
      idle(8);
      chk(o_pad[1].oe, i_periph[1].oe);
      chk(o_pad[1].out & i_periph[1].oe,
         i_periph[1].out & i_periph[1].oe);
      chk(periph_in[1], (i_periph[1].oe & i_periph[1].out)
         | (~i_periph[1].oe & ext[1]));
      i_periph[1] = '0;
      $display("done: peripheral");
      // Second reset in mid-run clears direction and enables
      wr(gpio_pkg::ADDR_ANALOG, 8'hff);
      idle(1);
      i_rst <= 1'b1;
      idle(2);
      i_rst <= 1'b0;
      idle(2);
      chk(o_pad[5].oe, 8'h00);
      chk(o_analog_pin_enable, 8'h00);
      rd(5'h0b, 8'h00);
      $display("done: mid-run reset");
      results();
   end
endmodule // gpio_ports_tb

`default_nettype wire
